// ### logic/asr_pkg.sv
package asr_pkg;
    // device geometry
    localparam int ASR_ADDR_W = 17;
    localparam int ASR_DATA_W = 8;
    localparam int ASR_WORDS = 131072;
    // clock and pin timing, in ns as printed for the slowest speed grade
    localparam int ASR_CLK_NS = 50;
    localparam int ASR_ACCESS_NS = 20;
    localparam int ASR_WPULSE_NS = 20;
    localparam int ASR_HIZ_NS = 9;
    // least times round up to whole cycles, never below one
    localparam int ASR_ACCESS_CYC_I = (ASR_ACCESS_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
    localparam int ASR_WPULSE_CYC_I = (ASR_WPULSE_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
    localparam int ASR_HIZ_CYC_I = (ASR_HIZ_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
    localparam logic [3:0] ASR_ACCESS_CYC = 4'(ASR_ACCESS_CYC_I < 1 ? 1 : ASR_ACCESS_CYC_I);
    localparam logic [3:0] ASR_WPULSE_CYC = 4'(ASR_WPULSE_CYC_I < 1 ? 1 : ASR_WPULSE_CYC_I);
    localparam logic [3:0] ASR_HIZ_CYC = 4'(ASR_HIZ_CYC_I < 1 ? 1 : ASR_HIZ_CYC_I);
    // extra gate span so a read byte crosses the second sync flop before capture
    localparam logic [3:0] ASR_SYNC_CYC = 4'h1;
    // reset values of the pins (all strobes inactive high)
    localparam logic ASR_STROBE_IDLE = 1'b1;
    localparam logic [ASR_DATA_W-1:0] ASR_DATA_RST = 8'h00;

    // user request: one word access
    typedef struct packed {
        logic write;
        logic [ASR_ADDR_W-1:0] word_index;
        logic [ASR_DATA_W-1:0] wdata;
    } asr_req_t;

    // memory-side pin bundle driven by the controller
    typedef struct packed {
        logic [ASR_ADDR_W-1:0] word_index;
        logic sel_n;
        logic wstb_n;
        logic ogate_n;
    } asr_pins_t;

    // access sequencer, gray along idle->setup->strobe->recover
    typedef enum logic [1:0] {
        ASR_IDLE = 2'b00,
        ASR_SETUP = 2'b01,
        ASR_STROBE = 2'b11,
        ASR_RECOVER = 2'b10
    } asr_state_t;
endpackage

// ### logic/asr_delay.sv
`timescale 1ns/1ps
`default_nettype none
// countdown timer: a load starts it, done pulses on the last cycle of the span
module asr_delay (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // control
    input wire logic load_in,
    input wire logic [3:0] count_in,
    // status
    output logic done_out
);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    // next count; done is flagged as the count steps from one to zero
    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        if (load_in) begin
            cnt_nxt = count_in;
        end else if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
            done_nxt = (cnt_r == 4'h1);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cnt_r <= 4'h0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done_out = done_r;
endmodule
`default_nettype wire

// ### logic/asr_ctrl.sv
// Behaviour
// (RULE1) memory holds 131072 bytes addressed by a 17-bit word index
// (RULE2) one set of 8 shared data lines carries both directions
// (RULE3) select high deselects the memory; its data lines float
// (RULE4) select low, strobe and gate high: memory neither writes nor drives
// (RULE5) select low, strobe high, gate low: memory drives the addressed byte
// (RULE6) select and strobe low: memory writes whatever the gate does
// (RULE7) controller holds the write strobe high through every read
// (RULE8) a write is active only while select and strobe are both low
// (RULE9) the later falling of select and strobe opens the write
// (RULE10) the first rising of select or strobe closes the write
// (RULE11) select falling with or after strobe keeps memory outputs off
// (RULE12) read condition makes the memory drive, even next to a write
// (RULE13) a read after a write returns the new address's content
// (RULE14) controller never drives against the memory while it drives
// (RULE15) controller avoids any overlap of its drive with the memory's
// (RULE16) address is valid no later than select falls on a read
// (RULE17) the close of the write stores the byte; other words stay
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // user request side
    input wire logic req_valid_in,
    input wire asr_pkg::asr_req_t req_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [asr_pkg::ASR_DATA_W-1:0] rsp_data_out,
    // memory pins
    output asr_pkg::asr_pins_t pins_out,
    input wire logic [asr_pkg::ASR_DATA_W-1:0] shared_data_lines_in,
    output logic [asr_pkg::ASR_DATA_W-1:0] shared_data_lines_out,
    output logic shared_data_lines_oe_n_out
);
    import asr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    asr_state_t state_r, state_nxt;
    asr_req_t cur_r, cur_nxt;
    asr_pins_t pins_r, pins_nxt;
    logic [ASR_DATA_W-1:0] dout_r, dout_nxt;
    logic oe_n_r, oe_n_nxt;
    logic ready_r, ready_nxt;
    logic rsp_v_r, rsp_v_nxt;
    logic [ASR_DATA_W-1:0] rsp_d_r, rsp_d_nxt;
    logic [ASR_DATA_W-1:0] din_meta_r, din_sync_r;
    logic tmr_load;
    logic [3:0] tmr_count;
    logic tmr_done;

    ////////////////////////////////////////////////////////////////////////
    // read data come from a pin, so two flops before anything looks at them;
    // the price is read latency: the gate must stay open until the byte
    // sampled after the gate opened has reached the second flop
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            din_meta_r <= ASR_DATA_RST;
            din_sync_r <= ASR_DATA_RST;
        end else begin
            din_meta_r <= shared_data_lines_in;
            din_sync_r <= din_meta_r;
        end
    end

    // one timer serves setup, strobe width and turnaround spans
    asr_delay u_delay (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .load_in(tmr_load),
        .count_in(tmr_count),
        .done_out(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer next-state logic; with every span one cycle an access runs:
    //   take edge: index out, ready low, write byte driven for writes
    //   +2: select falls together with strobe (write) or gate (read)
    //   +4: write closes, strobe and select rise together
    //   +5: controller lets go of the lines after a write
    //   +5: read answer from the byte sampled one cycle after the gate
    //       opened; select and gate rise with it
    //   +6 write, +7 read: ready again
    always_comb begin
        state_nxt = state_r;
        cur_nxt = cur_r;
        pins_nxt = pins_r;
        dout_nxt = dout_r;
        oe_n_nxt = oe_n_r;
        ready_nxt = ready_r;
        rsp_v_nxt = 1'b0;
        rsp_d_nxt = rsp_d_r;
        tmr_load = 1'b0;
        tmr_count = ASR_ACCESS_CYC;
        case (state_r)
            ASR_IDLE: begin
                if (req_valid_in && ready_r) begin
                    cur_nxt = req_in;
                    ready_nxt = 1'b0;
                    // address goes out before or with select [RULE16] [RULE1]
                    pins_nxt.word_index = req_in.word_index;
                    pins_nxt.sel_n = ASR_STROBE_IDLE;
                    pins_nxt.wstb_n = ASR_STROBE_IDLE;
                    pins_nxt.ogate_n = ASR_STROBE_IDLE;
                    if (req_in.write) begin
                        // gate stays high so the memory never drives [RULE15] [RULE6]
                        dout_nxt = req_in.wdata;
                        oe_n_nxt = 1'b0; // [RULE2]
                    end
                    tmr_load = 1'b1;
                    tmr_count = ASR_HIZ_CYC;
                    state_nxt = ASR_SETUP;
                end
            end
            ASR_SETUP: begin
                if (tmr_done) begin
                    // strobe and select fall together; select not earlier [RULE11] [RULE9]
                    pins_nxt.sel_n = 1'b0;
                    if (cur_r.write) begin
                        pins_nxt.wstb_n = 1'b0; // [RULE8]
                        tmr_count = ASR_WPULSE_CYC;
                    end else begin
                        // strobe stays high through reads [RULE7] [RULE5] [RULE12]
                        pins_nxt.ogate_n = 1'b0;
                        // gate stays open until the byte has passed both sync flops [RULE5]
                        tmr_count = ASR_ACCESS_CYC + ASR_SYNC_CYC;
                    end
                    tmr_load = 1'b1;
                    state_nxt = ASR_STROBE;
                end
            end
            ASR_STROBE: begin
                if (tmr_done) begin
                    if (cur_r.write) begin
                        // strobe rises together with select, data still held, closing the write [RULE10] [RULE17]
                        pins_nxt.wstb_n = ASR_STROBE_IDLE;
                    end else begin
                        // fresh address: data is the new word's content [RULE13]
                        rsp_d_nxt = din_sync_r;
                        rsp_v_nxt = 1'b1;
                        pins_nxt.ogate_n = ASR_STROBE_IDLE;
                    end
                    // deselect leaves the memory floating [RULE3] [RULE4]
                    pins_nxt.sel_n = ASR_STROBE_IDLE;
                    tmr_load = 1'b1;
                    tmr_count = ASR_HIZ_CYC;
                    state_nxt = ASR_RECOVER;
                end
            end
            ASR_RECOVER: begin
                // release the lines only after the strobe is up; no contention [RULE14]
                oe_n_nxt = 1'b1;
                if (tmr_done) begin
                    ready_nxt = 1'b1;
                    state_nxt = ASR_IDLE;
                end
            end
            default: begin
                state_nxt = ASR_IDLE;
                ready_nxt = 1'b1;
                oe_n_nxt = 1'b1;
            end
        endcase
        // last line of defence: never drive while the gate is about to open [RULE15]
        if (!pins_nxt.ogate_n) begin
            oe_n_nxt = 1'b1;
        end
    end

    // registers only; pins idle inactive and released from reset onward
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state_r <= ASR_IDLE;
            cur_r <= '0;
            pins_r <= '{word_index: '0, sel_n: ASR_STROBE_IDLE, wstb_n: ASR_STROBE_IDLE,
                        ogate_n: ASR_STROBE_IDLE};
            dout_r <= ASR_DATA_RST;
            oe_n_r <= 1'b1;
            ready_r <= 1'b1;
            rsp_v_r <= 1'b0;
            rsp_d_r <= ASR_DATA_RST;
        end else begin
            state_r <= state_nxt;
            cur_r <= cur_nxt;
            pins_r <= pins_nxt;
            dout_r <= dout_nxt;
            oe_n_r <= oe_n_nxt;
            ready_r <= ready_nxt;
            rsp_v_r <= rsp_v_nxt;
            rsp_d_r <= rsp_d_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign pins_out = pins_r;
    assign shared_data_lines_out = dout_r;
    assign shared_data_lines_oe_n_out = oe_n_r;
    assign req_ready_out = ready_r;
    assign rsp_valid_out = rsp_v_r;
    assign rsp_data_out = rsp_d_r;
endmodule
`default_nettype wire

// ### dv/asr_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_assertions (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // user side
    input wire logic req_valid_in,
    input wire asr_pkg::asr_req_t req_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    // memory pins
    input wire asr_pkg::asr_pins_t pins_out,
    input wire logic shared_data_lines_oe_n_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_take; req_valid_in && req_ready_out |=> !req_ready_out; endproperty
    a_take: assert property (p_take) else $error("ready stayed high after a take");
    property p_rd_rsp; req_valid_in && req_ready_out && !req_in.write |-> ##6 rsp_valid_out;
    endproperty
    a_rd_rsp: assert property (p_rd_rsp) else $error("read answer late");
    property p_pulse; rsp_valid_out |=> !rsp_valid_out; endproperty
    a_pulse: assert property (p_pulse) else $error("answer pulse too long");
    property p_back; req_valid_in && req_ready_out |-> ##[7:8] req_ready_out; endproperty
    a_back: assert property (p_back) else $error("ready did not return");
    property p_rd_wstb; !pins_out.sel_n && !pins_out.ogate_n |-> pins_out.wstb_n; endproperty
    a_rd_wstb: assert property (p_rd_wstb) else $error("strobe low in a read");
    property p_gate_off; !pins_out.ogate_n |-> shared_data_lines_oe_n_out; endproperty
    a_gate_off: assert property (p_gate_off) else $error("drive during read");
    property p_open; $fell(pins_out.wstb_n) |-> $fell(pins_out.sel_n); endproperty
    a_open: assert property (p_open) else $error("write opened apart");
    property p_close; $rose(pins_out.wstb_n) |-> $rose(pins_out.sel_n); endproperty
    a_close: assert property (p_close) else $error("write closed apart");
    property p_release;
        $rose(pins_out.wstb_n) |-> !shared_data_lines_oe_n_out ##1 shared_data_lines_oe_n_out;
    endproperty
    a_release: assert property (p_release) else $error("data release wrong");
    property p_addr; !pins_out.sel_n |=> pins_out.sel_n || $stable(pins_out.word_index); endproperty
    a_addr: assert property (p_addr) else $error("index moved while selected");
endmodule
bind asr_ctrl asr_ctrl_assertions chk_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .pins_out(pins_out),
    .shared_data_lines_oe_n_out(shared_data_lines_oe_n_out));
`default_nettype wire

// ### dv/asr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_mem_model (
    // pins from the controller
    input wire asr_pkg::asr_pins_t pins_in,
    input wire logic [7:0] lines_in,
    // what the memory puts on the shared lines
    output logic [7:0] drive_out,
    output logic drive_en_out
);
    import asr_pkg::*;
    logic [7:0] mem [int];
    logic wr_act;
    // write interval is the overlap of both lows only
    assign wr_act = !pins_in.sel_n && !pins_in.wstb_n;
    // store at the close; other words untouched
    always @(negedge wr_act) mem[pins_in.word_index] = lines_in;
    // drive only in the read condition
    always @(pins_in or wr_act) begin
        drive_en_out = !pins_in.sel_n && pins_in.wstb_n && !pins_in.ogate_n;
        drive_out = mem.exists(pins_in.word_index) ? mem[pins_in.word_index] : 8'h00;
        // released lines show the inverse so a stale byte can never pass
        if (!drive_en_out) drive_out = ~drive_out;
    end
endmodule
`default_nettype wire

// ### dv/asr_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_test;
    import asr_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    asr_req_t req_in = '0;
    logic req_ready_out, rsp_valid_out, dq_oe_n, mem_en;
    logic [7:0] rsp_data_out, dq_ctrl, dq_mem, dq_line;
    asr_pins_t pins;
    logic [7:0] mirror [int];
    logic [7:0] exp_q [$];
    int error_cnt = 0;
    int n_checks = 0;
    ////////////////////////////////////////////////////////////////////////////////
    always #25 sys_clk_in = ~sys_clk_in;
    // the controller wins only while it drives; contention is the checker's job
    assign dq_line = (dq_oe_n === 1'b0) ? dq_ctrl : dq_mem;
    asr_ctrl dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
        .req_in(req_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_data_out(rsp_data_out), .pins_out(pins), .shared_data_lines_in(dq_line),
        .shared_data_lines_out(dq_ctrl), .shared_data_lines_oe_n_out(dq_oe_n));
    asr_mem_model mdl_u (.pins_in(pins), .lines_in(dq_line), .drive_out(dq_mem),
        .drive_en_out(mem_en));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    // hold valid until a ready edge, then note the expected read byte
    task automatic access(input logic w, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_valid_in = 1'b1;
        req_in = '{w, a, d};
        while (req_ready_out !== 1'b1 && n < 40) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        if (w) mirror[a] = d;
        else exp_q.push_back(mirror[a]);
        @(posedge sys_clk_in);
        #1;
    endtask
    task automatic end_test(input string name);
        int n;
        req_valid_in = 1'b0;
        for (n = 0; n < 20 && exp_q.size() > 0; n++) @(posedge sys_clk_in);
        #1;
        chk(8'h00, 8'(exp_q.size()));
        $display("test %s done", name);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // read answers are matched against the oldest note
    always @(negedge sys_clk_in) begin
        if (rsp_valid_out === 1'b1)
            chk(exp_q.size() > 0 ? exp_q.pop_front() : ~rsp_data_out, rsp_data_out);
    end
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        error_cnt++;
        print_verdict;
    end
    initial begin
        logic [16:0] adr [12];
        int i;
        void'($urandom(32'hf380));
        repeat (6) @(posedge sys_clk_in);
        #1;
        rst_n_in = 1'b1;
        chk(8'h1f, {2'h0, rsp_valid_out, req_ready_out, pins.sel_n, pins.wstb_n, pins.ogate_n, dq_oe_n});
        $display("test reset done");
        // first and last word, back to back
        access(1'b1, 17'h00000, 8'($urandom));
        access(1'b1, 17'h1ffff, 8'($urandom));
        access(1'b1, 17'h00001, 8'($urandom));
        access(1'b0, 17'h1ffff, 8'h00);
        access(1'b0, 17'h00000, 8'h00);
        access(1'b0, 17'h00001, 8'h00);
        end_test("boundary");
        // random words, one overwritten, read back in reverse
        for (i = 0; i < 12; i++) begin
            adr[i] = 17'($urandom);
            access(1'b1, adr[i], 8'($urandom));
        end
        access(1'b1, adr[3], 8'($urandom));
        for (i = 11; i >= 0; i--) access(1'b0, adr[i], 8'h00);
        end_test("random");
        // read at a new index right after a write
        access(1'b1, 17'h0aaaa, 8'h5a);
        access(1'b0, 17'h00001, 8'h00);
        access(1'b1, 17'h00001, 8'ha5);
        access(1'b0, 17'h0aaaa, 8'h00);
        access(1'b0, 17'h00001, 8'h00);
        end_test("turnaround");
        print_verdict;
    end
endmodule
`default_nettype wire
